/* File: setpoint_pkg.sv */
package setpoint_pkg;
  // value widths: signed display counts, unsigned hysteresis, delays in tenths
  localparam int VAL_W = 18;
  localparam int HYS_W = 16;
  localparam int DLY_W = 13;
  localparam logic signed [VAL_W-1:0] SP_MIN = -18'sd19999;
  localparam logic signed [VAL_W-1:0] SP_MAX = 18'sd99999;
  localparam logic [HYS_W-1:0] HYS_MIN = 16'h0001;
  localparam logic [HYS_W-1:0] HYS_MAX = 16'hea5f;
  localparam logic [DLY_W-1:0] DLY_MAX = 13'h176f;
  // timing: one delay step is a tenth of a second
  localparam int CLK_HZ = 10000000;
  localparam int STEP_MS = 100;
  localparam int STEP_CYC_DEF = CLK_HZ / 1000 * STEP_MS;
  localparam int PRE_W = 20;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ADDR_SP1_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SP1_VAL = 8'h04;
  localparam logic [7:0] ADDR_SP1_HYS = 8'h08;
  localparam logic [7:0] ADDR_SP1_DLY = 8'h0c;
  localparam logic [7:0] ADDR_SP2_CTRL = 8'h10;
  localparam logic [7:0] ADDR_SP2_VAL = 8'h14;
  localparam logic [7:0] ADDR_SP2_HYS = 8'h18;
  localparam logic [7:0] ADDR_SP2_DLY = 8'h1c;
  localparam logic [7:0] ADDR_DISP = 8'h20;
  localparam logic [7:0] ADDR_CMD = 8'h24;
  localparam logic [7:0] ADDR_STAT = 8'h28;
  localparam logic [7:0] SP_STRIDE = 8'h10;
  localparam logic [7:0] ADDR_STAT_MASK = 8'hf0;
  // control field positions
  localparam int CF_ACT_LO = 0;
  localparam int CF_RST_LO = 2;
  localparam int CF_RDR = 4;
  localparam int CF_STBY = 5;
  localparam int CF_COLOR = 6;
  localparam int CF_EN = 7;
  localparam int CF_W = 8;
  localparam int DLY_OFF_LO = 16;
  localparam int CMD_SERIAL = 0;
  localparam int CMD_DISP_SEL = 1;
  localparam int CMD_RST_DSP = 2;
  localparam int CMD_UIN_DSP = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0080;

  typedef enum logic [1:0] {
    HIGH_ACT_BALANCED_HYST = 2'h0,
    LOW_ACT_BALANCED_HYST = 2'h1,
    HIGH_ACT_UNBALANCED_HYST = 2'h2,
    LOW_ACT_UNBALANCED_HYST = 2'h3
  } action_e;

  typedef enum logic [1:0] {
    AUTO_CLEAR = 2'h0,
    LATCH_IMMEDIATE_CLEAR = 2'h1,
    LATCH_DEFERRED_CLEAR = 2'h2
  } reset_mode_e;

  // one setpoint's settings
  typedef struct packed {
    logic enable;
    logic colorChange;
    logic standby;
    logic resetWithDisplay;
    reset_mode_e resetMode;
    action_e action;
    logic signed [VAL_W-1:0] setpoint;
    logic [HYS_W-1:0] hysteresis;
    logic [DLY_W-1:0] onDelay;
    logic [DLY_W-1:0] offDelay;
  } sp_cfg_s;

  // reset requests for one setpoint
  typedef struct packed {
    logic manual;
    logic serial;
    logic powerUp;
  } sp_req_s;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_OFF = 4'h2,
    ST_ON = 4'h4,
    ST_LATCHED = 4'h8
  } out_state_e;

  function automatic logic signed [VAL_W-1:0] clampSp(input logic signed [VAL_W-1:0] v);
    if (v < SP_MIN) begin
      clampSp = SP_MIN;
    end else if (v > SP_MAX) begin
      clampSp = SP_MAX;
    end else begin
      clampSp = v;
    end
  endfunction

  function automatic logic [HYS_W-1:0] clampHys(input logic [HYS_W-1:0] v);
    if (v < HYS_MIN) begin
      clampHys = HYS_MIN;
    end else if (v > HYS_MAX) begin
      clampHys = HYS_MAX;
    end else begin
      clampHys = v;
    end
  endfunction

  function automatic logic [DLY_W-1:0] clampDly(input logic [DLY_W-1:0] v);
    clampDly = (v > DLY_MAX) ? DLY_MAX : v;
  endfunction
endpackage

/* File: tenth_tick.sv */
`timescale 1ns/1ps
// divides the clock to one pulse per tenth of a second
module tenth_tick #(
  parameter int STEP_CYC = setpoint_pkg::STEP_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  import setpoint_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] count;
    logic tick;
  } tick_s;

  tick_s state_reg;
  tick_s state_next;

  // free-running prescaler
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count == PRE_W'(STEP_CYC - 1)) begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + PRE_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule

/* File: setpoint_channel.sv */
`timescale 1ns/1ps
// one setpoint: thresholds, delays, reset modes, standby
module setpoint_channel (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input setpoint_pkg::sp_cfg_s cfg,
  input wire logic signed [setpoint_pkg::VAL_W-1:0] displayValue,
  input setpoint_pkg::sp_req_s req,
  output logic outputOn,
  output logic deferPending
);
  import setpoint_pkg::*;

  typedef struct packed {
    out_state_e fsm;
    logic [DLY_W-1:0] timer;
    logic pending;
    logic out;
  } ch_s;

  ch_s state_reg;
  ch_s state_next;

  logic signed [VAL_W+1:0] sp;
  logic signed [VAL_W+1:0] hys;
  logic signed [VAL_W+1:0] dv;
  logic signed [VAL_W+1:0] onTh;
  logic signed [VAL_W+1:0] offTh;
  logic highAct;
  logic onCond;
  logic offCond;
  logic manualClr;

  // thresholds; setpoint, hysteresis and display share one decimal scaling
  always_comb begin
    sp = (VAL_W+2)'(cfg.setpoint);
    hys = (VAL_W+2)'($signed({1'b0, cfg.hysteresis}));
    dv = (VAL_W+2)'(displayValue);
    highAct = (cfg.action == HIGH_ACT_BALANCED_HYST) || (cfg.action == HIGH_ACT_UNBALANCED_HYST);
    case (cfg.action)
      HIGH_ACT_BALANCED_HYST: begin
        onTh = sp + (hys >>> 1);
        offTh = sp - (hys >>> 1);
      end
      LOW_ACT_BALANCED_HYST: begin
        onTh = sp - (hys >>> 1);
        offTh = sp + (hys >>> 1);
      end
      HIGH_ACT_UNBALANCED_HYST: begin
        onTh = sp;
        offTh = sp - hys;
      end
      LOW_ACT_UNBALANCED_HYST: begin
        onTh = sp;
        offTh = sp + hys;
      end
      default: begin
        onTh = sp;
        offTh = sp;
      end
    endcase
    onCond = highAct ? (dv >= onTh) : (dv <= onTh);
    offCond = highAct ? (dv < offTh) : (dv > offTh);
    manualClr = req.manual || req.serial;
  end

  // output state machine; timer counts tenths and restarts when cause goes away
  always_comb begin
    state_next = state_reg;
    case (state_reg.fsm)
      ST_STANDBY: begin
        // held off after power-up or a manual clear until the trigger point is crossed anew
        state_next.out = 1'b0;
        if (!onCond) begin
          state_next.fsm = ST_OFF;
        end
      end
      ST_OFF: begin
        if (onCond) begin
          if (state_reg.timer >= cfg.onDelay) begin
            state_next.fsm = (cfg.resetMode == AUTO_CLEAR) ? ST_ON : ST_LATCHED;
            state_next.out = 1'b1;
            state_next.timer = '0;
          end else if (tick) begin
            state_next.timer = state_reg.timer + DLY_W'(1);
          end
        end else begin
          state_next.timer = '0;
        end
      end
      ST_ON: begin
        if (req.manual) begin
          state_next.fsm = ST_STANDBY;
          state_next.out = 1'b0;
          state_next.timer = '0;
        end else if (offCond) begin
          if (state_reg.timer >= cfg.offDelay) begin
            state_next.fsm = ST_OFF;
            state_next.out = 1'b0;
            state_next.timer = '0;
          end else if (tick) begin
            state_next.timer = state_reg.timer + DLY_W'(1);
          end
        end else begin
          state_next.timer = '0;
        end
      end
      ST_LATCHED: begin
        if (cfg.resetMode == LATCH_DEFERRED_CLEAR) begin
          if (manualClr) begin
            state_next.pending = 1'b1;
          end
          if ((state_reg.pending || manualClr) && offCond) begin
            state_next.fsm = ST_OFF;
            state_next.out = 1'b0;
            state_next.pending = 1'b0;
            state_next.timer = '0;
          end
        end else if (manualClr) begin
          state_next.fsm = ST_STANDBY;
          state_next.out = 1'b0;
          state_next.timer = '0;
        end
      end
      default: begin
        state_next = '{fsm: ST_OFF, timer: '0, pending: 1'b0, out: 1'b0};
      end
    endcase
    // power-up pass: pending deferral dropped unless re-asserted; latched comes up off below setpoint
    if (req.powerUp) begin
      state_next.pending = manualClr && (cfg.resetMode == LATCH_DEFERRED_CLEAR);
      if (dv < sp) begin
        state_next.out = 1'b0;
        state_next.fsm = cfg.standby ? ST_STANDBY : ST_OFF;
        state_next.timer = '0;
      end else if (cfg.standby) begin
        state_next.out = 1'b0;
        state_next.fsm = ST_STANDBY;
        state_next.timer = '0;
      end
    end
    if (!cfg.enable) begin
      state_next = '{fsm: ST_OFF, timer: '0, pending: 1'b0, out: 1'b0};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{fsm: ST_OFF, timer: '0, pending: 1'b0, out: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign outputOn = state_reg.out;
  assign deferPending = state_reg.pending;
endmodule

/* File: setpoint_alarm_output.sv */
`timescale 1ns/1ps
module setpoint_alarm_output #(
  parameter int STEP_CYC = setpoint_pkg::STEP_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [setpoint_pkg::VAL_W-1:0] displayValue,
  input wire logic inputDisplayed,
  input wire logic resetButton,
  input wire logic userInput,
  input wire logic powerUp,
  output logic [1:0] setpointOut,
  output logic backlightAlt
);
  import setpoint_pkg::*;

  typedef struct packed {
    logic [1:0][CF_W-1:0] ctrl;
    logic [1:0][VAL_W-1:0] spVal;
    logic [1:0][HYS_W-1:0] hys;
    logic [1:0][DLY_W-1:0] onDly;
    logic [1:0][DLY_W-1:0] offDly;
    logic [3:0] cmd;
    logic serialPulse;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] prevOut;
    logic color;
    logic btnPrev;
    logic uinPrev;
  } top_s;

  top_s state_reg;
  top_s state_next;
  sp_cfg_s cfg [2];
  sp_req_s req [2];
  logic [1:0] chOut;
  logic [1:0] chPend;
  logic tick;
  logic access;
  logic [7:0] regOff;
  logic [0:0] chSel;
  logic btnEdge;
  logic uinEdge;
  logic manualRaw;
  logic dispCoupled;

  // masks a register word by byte enables
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    laneMerge = old;
  endfunction

  tenth_tick #(
    .STEP_CYC(STEP_CYC)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  // setting views for both channels
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cfg[i].action = action_e'(state_reg.ctrl[i][CF_ACT_LO +: 2]);
      cfg[i].resetMode = reset_mode_e'(state_reg.ctrl[i][CF_RST_LO +: 2]);
      cfg[i].resetWithDisplay = state_reg.ctrl[i][CF_RDR];
      cfg[i].standby = state_reg.ctrl[i][CF_STBY];
      cfg[i].colorChange = state_reg.ctrl[i][CF_COLOR];
      // setpoint 1 is always present; setpoint 2 has its own enable
      cfg[i].enable = (i == 0) ? 1'b1 : state_reg.ctrl[i][CF_EN];
      cfg[i].setpoint = state_reg.spVal[i];
      cfg[i].hysteresis = state_reg.hys[i];
      cfg[i].onDelay = state_reg.onDly[i];
      cfg[i].offDelay = state_reg.offDly[i];
    end
  end

  // reset sources: rising edges of button and user input
  always_comb begin
    btnEdge = resetButton && !state_reg.btnPrev;
    uinEdge = userInput && !state_reg.uinPrev;
    manualRaw = btnEdge || uinEdge;
    // coupled reset only when the source is assigned to display reset and input is shown
    dispCoupled = inputDisplayed && state_reg.cmd[CMD_DISP_SEL] &&
                  ((btnEdge && state_reg.cmd[CMD_RST_DSP]) || (uinEdge && state_reg.cmd[CMD_UIN_DSP]));
    for (int i = 0; i < 2; i++) begin
      // with coupling on, only a qualified display reset counts as a manual reset; the serial reset still clears latched outputs
      req[i].manual = cfg[i].resetWithDisplay ? dispCoupled : manualRaw;
      req[i].serial = state_reg.serialPulse;
      req[i].powerUp = powerUp;
    end
  end

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ch
      setpoint_channel u_ch (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick),
        .cfg(cfg[g]),
        .displayValue(displayValue),
        .req(req[g]),
        .outputOn(chOut[g]),
        .deferPending(chPend[g])
      );
    end
  endgenerate

  assign access = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign regOff = wb_adr_i & 8'h0f;
  assign chSel = (wb_adr_i >= ADDR_SP2_CTRL) ? 1'b1 : 1'b0;

  // bus slave, command bits and backlight colour
  always_comb begin
    state_next = state_reg;
    state_next.ack = access;
    state_next.serialPulse = 1'b0;
    state_next.btnPrev = resetButton;
    state_next.uinPrev = userInput;
    state_next.prevOut = chOut;
    // a write lands at the edge where the master sees ack high
    if (wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack) begin
      if (wb_adr_i < ADDR_DISP) begin
        case (regOff)
          ADDR_SP1_CTRL: begin
            state_next.ctrl[chSel] = CF_W'(laneMerge(32'(state_reg.ctrl[chSel]), wb_dat_i, wb_sel_i));
          end
          ADDR_SP1_VAL: begin
            state_next.spVal[chSel] = clampSp(VAL_W'(laneMerge(32'(state_reg.spVal[chSel]), wb_dat_i, wb_sel_i)));
          end
          ADDR_SP1_HYS: begin
            state_next.hys[chSel] = clampHys(HYS_W'(laneMerge(32'(state_reg.hys[chSel]), wb_dat_i, wb_sel_i)));
          end
          ADDR_SP1_DLY: begin
            state_next.onDly[chSel] = clampDly(DLY_W'(laneMerge(32'(state_reg.onDly[chSel]), wb_dat_i, wb_sel_i)));
            state_next.offDly[chSel] = clampDly(DLY_W'(laneMerge(32'(state_reg.offDly[chSel]) << DLY_OFF_LO,
                                                                 wb_dat_i, wb_sel_i) >> DLY_OFF_LO));
          end
          default: begin
          end
        endcase
      end else if (wb_adr_i == ADDR_CMD) begin
        // serial reset is a pulse; the selector bits are stored
        state_next.cmd = 4'(laneMerge(32'(state_reg.cmd), wb_dat_i, wb_sel_i) & 32'h0000_000e);
        state_next.serialPulse = wb_sel_i[0] && wb_dat_i[CMD_SERIAL];
      end
    end
    // read data registered; unmapped reads give zero
    state_next.rdata = '0;
    if (access && !wb_we_i) begin
      if (wb_adr_i < ADDR_DISP) begin
        case (regOff)
          ADDR_SP1_CTRL: state_next.rdata = 32'(state_reg.ctrl[chSel]);
          ADDR_SP1_VAL: state_next.rdata = 32'(signed'(state_reg.spVal[chSel]));
          ADDR_SP1_HYS: state_next.rdata = 32'(state_reg.hys[chSel]);
          ADDR_SP1_DLY: state_next.rdata = 32'(state_reg.onDly[chSel]) | (32'(state_reg.offDly[chSel]) << DLY_OFF_LO);
          default: state_next.rdata = '0;
        endcase
      end else begin
        case (wb_adr_i)
          ADDR_DISP: state_next.rdata = 32'(signed'(displayValue));
          ADDR_CMD: state_next.rdata = 32'(state_reg.cmd);
          ADDR_STAT: state_next.rdata = {27'h0, state_reg.color, chPend, chOut};
          default: state_next.rdata = '0;
        endcase
      end
    end
    // backlight toggles once per output transition of a channel with colour change on, so both channels changing in one cycle with colour change on leave it unchanged
    for (int i = 0; i < 2; i++) begin
      if (cfg[i].colorChange && (chOut[i] != state_reg.prevOut[i])) begin
        state_next.color = !state_next.color;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.ctrl[0] <= CF_W'(CTRL_RST);
      state_reg.hys[0] <= HYS_MIN;
      state_reg.hys[1] <= HYS_MIN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign setpointOut = chOut;
  assign backlightAlt = state_reg.color;
endmodule

/* File: relay_model.sv */
`timescale 1ns/1ps
// output card: each contact follows its coil one cycle later
module relay_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] drive,
  output logic [1:0] contact
);
  // contacts open while the meter is held in reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      contact <= 2'h0;
    end else begin
      contact <= drive;
    end
  end
endmodule

/* File: setpoint_alarm_output_sva.sv */
`timescale 1ns/1ps
// shadows setpoint config from bus writes; full-word, in-range writes assumed
module setpoint_alarm_output_sva #(
  parameter int STEP_CYC = setpoint_pkg::STEP_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic signed [setpoint_pkg::VAL_W-1:0] displayValue,
  input wire logic inputDisplayed,
  input wire logic resetButton,
  input wire logic userInput,
  input wire logic powerUp,
  input wire logic [1:0] setpointOut,
  input wire logic backlightAlt
);
  import setpoint_pkg::*;
  logic [7:0] ctrl1Reg; // setpoint 1 control
  logic signed [VAL_W-1:0] sp1Reg; // setpoint 1 value
  logic [HYS_W-1:0] hys1Reg; // setpoint 1 hysteresis
  logic [DLY_W-1:0] off1Reg; // setpoint 1 off delay
  logic en2Reg; // setpoint 2 enable
  logic [2:0] offCntReg; // cycles with setpoint 2 disabled
  logic [2:0] lowCntReg; // cycles below unbalanced off point
  logic [1:0] outD1Reg; // outputs one cycle back
  logic [1:0] outD2Reg; // outputs two cycles back
  logic wrDone; // write lands at this edge
  int offPoint; // high unbalanced off point
  assign wrDone = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign offPoint = int'(sp1Reg) - int'(hys1Reg);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // lowCntReg restarts on any write, so a config change is never judged early; offCntReg restarts only while setpoint 2 is enabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1Reg <= 8'h80;
      sp1Reg <= '0;
      hys1Reg <= 16'h0001;
      off1Reg <= '0;
      en2Reg <= 1'b0;
      offCntReg <= 3'h0;
      lowCntReg <= 3'h0;
      outD1Reg <= 2'h0;
      outD2Reg <= 2'h0;
    end else begin
      if (wrDone && wb_adr_i == ADDR_SP1_CTRL) begin
        ctrl1Reg <= wb_dat_i[7:0];
      end
      if (wrDone && wb_adr_i == ADDR_SP1_VAL) begin
        sp1Reg <= wb_dat_i[VAL_W-1:0];
      end
      if (wrDone && wb_adr_i == ADDR_SP1_HYS) begin
        hys1Reg <= wb_dat_i[HYS_W-1:0];
      end
      if (wrDone && wb_adr_i == ADDR_SP1_DLY) begin
        off1Reg <= wb_dat_i[28:16];
      end
      if (wrDone && wb_adr_i == ADDR_SP2_CTRL) begin
        en2Reg <= wb_dat_i[7];
      end
      offCntReg <= en2Reg ? 3'h0 : offCntReg + 3'(offCntReg != 3'h7);
      lowCntReg <= (wrDone || displayValue >= offPoint) ? 3'h0 : lowCntReg + 3'(lowCntReg != 3'h7);
      outD1Reg <= setpointOut;
      outD2Reg <= outD1Reg;
    end
  end
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_AUTO_OFF: assert property (lowCntReg >= 3'h3 && ctrl1Reg[3:0] == 4'h2 && off1Reg == '0 |-> !setpointOut[0])
    else $error("auto output on below off point");
  AST_MANUAL_CLEAR: assert property (($rose(resetButton) || $rose(userInput)) && ctrl1Reg[3:2] != 2'h2
    && !ctrl1Reg[4]
    && setpointOut[0] |-> ##[1:3] !setpointOut[0]) else $error("manual reset did not clear");
  AST_POWERUP_OFF: assert property (powerUp && ctrl1Reg[3:2] != 2'h0 && !ctrl1Reg[0]
    && displayValue < sp1Reg |=> !setpointOut[0]) else $error("latched output kept over power cycle");
  AST_SP2_DISABLED: assert property (offCntReg >= 3'h4 |-> !setpointOut[1])
    else $error("disabled setpoint 2 active");
  AST_COLOR_CAUSE: assert property ($changed(backlightAlt) |-> setpointOut != outD1Reg || outD1Reg != outD2Reg)
    else $error("colour changed without output change");
  cover property ($rose(setpointOut[0]));
  cover property ($fell(setpointOut[0]) && ctrl1Reg[3:2] == 2'h1);
  cover property ($changed(backlightAlt));
endmodule
bind setpoint_alarm_output setpoint_alarm_output_sva #(.STEP_CYC(STEP_CYC)) setpoint_alarm_output_sva_inst (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .displayValue(displayValue), .inputDisplayed(inputDisplayed), .resetButton(resetButton),
  .userInput(userInput), .powerUp(powerUp), .setpointOut(setpointOut), .backlightAlt(backlightAlt));

/* File: test_setpoint_alarm_output.sv */
`timescale 1ns/1ps
// random and corner-case bench; setpoint 1000, hysteresis 100 after the clamping checks
module test_setpoint_alarm_output;
  import setpoint_pkg::*;
  `define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] datI = '0;
  logic [31:0] datO;
  logic ack;
  logic signed [VAL_W-1:0] dv = '0; // displayed value
  logic disp = 1'b0; // input value shown
  logic btn = 1'b0;
  logic uin = 1'b0;
  logic pwr = 1'b0;
  logic [1:0] spOut;
  logic color;
  logic [1:0] contact; // relay card contacts
  logic [31:0] rd; // last read data
  logic [15:0] lfsr = 16'h0002;
  logic ex; // expected output 1
  logic nx;
  logic col; // expected colour
  int mismatches = 0;
  int numChecks = 0;
  int cycles = 0;
  int a;
  int i;
  int v;
  always #50 clock = ~clock;
  setpoint_alarm_output #(.STEP_CYC(10)) setpoint_alarm_output_inst (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .displayValue(dv), .inputDisplayed(disp), .resetButton(btn),
    .userInput(uin), .powerUp(pwr), .setpointOut(spOut), .backlightAlt(color));
  relay_model relay_model_inst (.clock(clock), .rst_n(rst_n), .drive(spOut), .contact(contact));
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    lfsrNext = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // thresholds: balanced is +-50, unbalanced uses the full 100 on one side
  function automatic logic expOut(input logic [1:0] k, input logic cur, input int x);
    int onT;
    int offT;
    onT = k[0] ? 1000 - (k[1] ? 0 : 50) : 1000 + (k[1] ? 0 : 50);
    offT = k[0] ? 1000 + (k[1] ? 100 : 50) : 1000 - (k[1] ? 100 : 50);
    if (k[0]) begin
      expOut = (x <= onT) ? 1'b1 : (x > offT) ? 1'b0 : cur;
    end else begin
      expOut = (x >= onT) ? 1'b1 : (x < offT) ? 1'b0 : cur;
    end
  endfunction
  // one classic cycle; the idle edge after it keeps drivers single per step
  task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    datI <= d;
    do @(posedge clock); while (ack !== 1'b1);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic go(input int x);
    dv <= VAL_W'(x);
    repeat (3) @(posedge clock);
  endtask
  // 0 button, 1 user input, 2 power cycle
  task automatic press(input int k);
    btn <= (k == 0);
    uin <= (k == 1);
    pwr <= (k == 2);
    @(posedge clock);
    btn <= 1'b0;
    uin <= 1'b0;
    pwr <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    xfer(ADDR_SP1_CTRL, 1'b0, '0);
    `CHK(rd, CTRL_RST)
    xfer(ADDR_SP2_CTRL, 1'b0, '0);
    `CHK(rd, 32'h0)
    xfer(8'h3c, 1'b0, '0);
    `CHK(rd, 32'h0)
    xfer(ADDR_SP1_VAL, 1'b1, 32'hffff8ad0);
    xfer(ADDR_SP1_VAL, 1'b0, '0);
    `CHK(rd, 32'hffffb1e1)
    xfer(ADDR_SP1_VAL, 1'b1, 32'h0001e848);
    xfer(ADDR_SP1_VAL, 1'b0, '0);
    `CHK(rd, 32'h0001869f)
    xfer(ADDR_SP1_HYS, 1'b1, 32'h0);
    xfer(ADDR_SP1_HYS, 1'b0, '0);
    `CHK(rd, 32'h1)
    xfer(ADDR_SP1_HYS, 1'b1, 32'hffff);
    xfer(ADDR_SP1_HYS, 1'b0, '0);
    `CHK(rd, 32'hea5f)
    xfer(ADDR_SP1_DLY, 1'b1, 32'hffffffff);
    xfer(ADDR_SP1_DLY, 1'b0, '0);
    `CHK(rd, 32'h176f176f)
    xfer(ADDR_SP1_VAL, 1'b1, 32'd1000);
    xfer(ADDR_SP1_HYS, 1'b1, 32'd100);
    xfer(ADDR_SP1_DLY, 1'b1, '0);
    // every action against random values around the thresholds
    for (a = 0; a < 4; a++) begin
      xfer(ADDR_SP1_CTRL, 1'b1, 32'h80 | a);
      go(a[0] ? 1300 : 700);
      ex = 1'b0;
      col = 1'b0;
      if (a == 2) xfer(ADDR_SP1_CTRL, 1'b1, 32'hc2);
      for (i = 0; i < 40; i++) begin
        lfsr = lfsrNext(lfsr);
        v = 800 + int'(lfsr % 16'd400);
        go(v);
        nx = expOut(2'(a), ex, v);
        col = col ^ (nx != ex);
        ex = nx;
        `CHK(spOut, 2'(ex))
        if (a == 2) `CHK(color, col)
      end
    end
    // on delay of 3 tenths, with a restart, then off delay of 2 tenths
    xfer(ADDR_SP1_CTRL, 1'b1, 32'h82);
    go(800);
    xfer(ADDR_SP1_DLY, 1'b1, 32'h00020003);
    go(1100);
    repeat (12) @(posedge clock);
    `CHK(spOut, 2'b00)
    go(950);
    go(1100);
    repeat (15) @(posedge clock);
    `CHK(spOut, 2'b00)
    repeat (30) @(posedge clock);
    `CHK(spOut, 2'b01)
    `CHK(contact, 2'b01)
    go(800);
    `CHK(spOut, 2'b01)
    repeat (30) @(posedge clock);
    `CHK(spOut, 2'b00)
    // latch with immediate clear: serial command, then button
    xfer(ADDR_SP1_DLY, 1'b1, '0);
    xfer(ADDR_SP1_CTRL, 1'b1, 32'h86);
    go(1100);
    go(800);
    `CHK(spOut, 2'b01)
    xfer(ADDR_CMD, 1'b1, 32'h1);
    repeat (2) @(posedge clock);
    `CHK(spOut, 2'b00)
    go(1100);
    press(0);
    `CHK(spOut, 2'b00)
    // automatic mode cleared from the user input
    xfer(ADDR_SP1_CTRL, 1'b1, 32'h82);
    go(800);
    go(1100);
    press(1);
    `CHK(spOut, 2'b00)
    // coupled reset: refused until source assigned and input shown
    xfer(ADDR_SP1_CTRL, 1'b1, 32'h92);
    go(800);
    go(1100);
    press(0);
    `CHK(spOut, 2'b01)
    xfer(ADDR_CMD, 1'b1, 32'h6);
    disp <= 1'b1;
    press(0);
    `CHK(spOut, 2'b00)
    // latch with deferred clear, then power cycles
    xfer(ADDR_SP1_CTRL, 1'b1, 32'h8a);
    go(800);
    go(1100);
    press(0);
    `CHK(spOut, 2'b01)
    xfer(ADDR_STAT, 1'b0, '0);
    `CHK(rd[2], 1'b1)
    go(800);
    `CHK(spOut, 2'b00)
    go(1100);
    press(0);
    press(2);
    xfer(ADDR_STAT, 1'b0, '0);
    `CHK(rd[2], 1'b0)
    go(950);
    press(2);
    `CHK(spOut, 2'b00)
    // standby: held off after power-up until the trigger is crossed again
    xfer(ADDR_SP1_CTRL, 1'b1, 32'ha2);
    go(1100);
    press(2);
    `CHK(spOut, 2'b00)
    go(800);
    go(1100);
    `CHK(spOut, 2'b01)
    xfer(ADDR_SP2_CTRL, 1'b1, 32'h80);
    go(1100);
    `CHK(spOut[1], 1'b1)
    print_verdict();
  end
endmodule
